/* File: core/fan_ramp_pkg.sv */
// constants for the fan duty ramp limiter
package fan_ramp_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_DUTY_ONE = 8'h30;
   localparam logic [7:0] IDX_DUTY_TWO = 8'h31;
   localparam logic [7:0] IDX_DUTY_THREE = 8'h32;
   localparam logic [7:0] IDX_RAMP_ONE = 8'h62;
   localparam logic [7:0] IDX_RAMP_TWO = 8'h63;
   // reset values
   localparam logic [7:0] DUTY_RESET = 8'hff;
   localparam logic [7:0] RAMP_RESET = 8'h00;
   // field positions
   localparam int SEL_CH1_LSB = 0;
   localparam int SEL_CH3_LSB = 0;
   localparam int SEL_CH2_LSB = 4;
   localparam int EN_CH1_BIT = 3;
   localparam int EN_CH3_BIT = 3;
   localparam int EN_CH2_BIT = 7;
   // slot grid and pacing
   localparam int SLOTS = 255;
   localparam logic [7:0] SLOT_LAST = 8'hfe;
   localparam int CLK_HZ = 50000000;
   localparam int FULL_RAMP_MS = 35000;
   localparam int UPDATE_CYCLES = (CLK_HZ / 1000) * FULL_RAMP_MS / SLOTS;
   // step sizes per code
   localparam logic [7:0] STEP_C0 = 8'h01;
   localparam logic [7:0] STEP_C1 = 8'h02;
   localparam logic [7:0] STEP_C2 = 8'h03;
   localparam logic [7:0] STEP_C3 = 8'h05;
   localparam logic [7:0] STEP_C4 = 8'h08;
   localparam logic [7:0] STEP_C5 = 8'h0c;
   localparam logic [7:0] STEP_C6 = 8'h18;
   localparam logic [7:0] STEP_C7 = 8'h30;
endpackage

/* File: core/fan_pwm_ramp_limiter.sv */
// three-channel fan duty ramp limiter with wishbone registers
// Contract
// [RL1] channel one step from ctrl one bits 2:0
// [RL2] channel three step from ctrl two bits 2:0
// [RL3] channel two step from ctrl two bits 6:4
// [RL4] update pacing gives 35 s full ramp
// [RL5] manual 0 to 100 takes 35 s
// [RL6] rising target never reverses the ramp
// [RL7] duty registers readable, writable, reset full
// [RL8] period split into 255 equal slots
// [RL9] each update steps held duty toward target
// [RL10] per-channel enable bits turn ramping on
// [RL11] land exactly on target, no overshoot
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_ramp_limiter
   import fan_ramp_pkg::*;
#(
   parameter int UPDATE_PERIOD = UPDATE_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [9:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // automatic control targets and mode
   input wire logic [2:0] auto_mode_i,
   input wire logic [7:0] target_one_i,
   input wire logic [7:0] target_two_i,
   input wire logic [7:0] target_three_i,
   // fan drive outputs
   output logic fan_drive_one_o,
   output logic fan_drive_two_o,
   output logic fan_drive_three_o
);
   // refuse a pacing too short for the tick spacing rule
   if (UPDATE_PERIOD < 3) begin : g_bad_period
      $error("UPDATE_PERIOD must be at least 3");
   end

   // step size lookup for a 3-bit code
   function automatic logic [7:0] step_of(input logic [2:0] code);
      case (code)
         3'h0: step_of = STEP_C0;
         3'h1: step_of = STEP_C1;
         3'h2: step_of = STEP_C2;
         3'h3: step_of = STEP_C3;
         3'h4: step_of = STEP_C4;
         3'h5: step_of = STEP_C5;
         3'h6: step_of = STEP_C6;
         default: step_of = STEP_C7;
      endcase
   endfunction

   logic [7:0] ramp_one;
   logic [7:0] ramp_two;
   logic [7:0] req [3];
   logic [7:0] held [3];
   logic [7:0] target [3];
   logic [7:0] step [3];
   logic [2:0] ramp_en;
   logic [7:0] slot;
   logic [31:0] tick_cnt;
   logic tick;

   // bus decode
   wire logic [7:0] idx = adr_i[9:2];
   wire logic req_now = cyc_i && stb_i && !ack_o;
   wire logic wr_now = req_now && we_i && sel_i[0];
   wire logic hit_d1 = (idx == IDX_DUTY_ONE);
   wire logic hit_d2 = (idx == IDX_DUTY_TWO);
   wire logic hit_d3 = (idx == IDX_DUTY_THREE);
   wire logic hit_r1 = (idx == IDX_RAMP_ONE);
   wire logic hit_r2 = (idx == IDX_RAMP_TWO);

   // step selection and enables per channel
   assign step[0] = step_of(ramp_one[SEL_CH1_LSB +: 3]); // [RL1]
   assign step[1] = step_of(ramp_two[SEL_CH2_LSB +: 3]); // [RL3]
   assign step[2] = step_of(ramp_two[SEL_CH3_LSB +: 3]); // [RL2]
   assign ramp_en = {ramp_two[EN_CH3_BIT], ramp_two[EN_CH2_BIT], ramp_one[EN_CH1_BIT]}; // [RL10]

   // target: automatic calculation or manual request
   assign target[0] = auto_mode_i[0] ? target_one_i : req[0];
   assign target[1] = auto_mode_i[1] ? target_two_i : req[1];
   assign target[2] = auto_mode_i[2] ? target_three_i : req[2];

   // read data mux
   wire logic [7:0] rd_byte = hit_d1 ? held[0] :
                              hit_d2 ? held[1] :
                              hit_d3 ? held[2] :
                              hit_r1 ? ramp_one :
                              hit_r2 ? ramp_two : 8'h00;

   // bus answer one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req_now;
         dat_o <= {24'h00_0000, rd_byte};
      end
   end

   // ramp control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ramp_one <= RAMP_RESET;
         ramp_two <= RAMP_RESET;
      end else begin
         if (wr_now && hit_r1) ramp_one <= dat_i[7:0];
         if (wr_now && hit_r2) ramp_two <= dat_i[7:0];
      end
   end

   // update pacing: one step opportunity per tick
   assign tick = (tick_cnt == UPDATE_PERIOD - 1);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt <= 32'h0000_0000;
      end else if (tick) begin
         tick_cnt <= 32'h0000_0000; // [RL4] [RL5]
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // slot counter over one pwm period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slot <= 8'h00;
      end else if (slot == SLOT_LAST) begin
         slot <= 8'h00; // [RL8]
      end else begin
         slot <= slot + 8'h01;
      end
   end

   // per-channel held duty and manual request
   logic [2:0] drive;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : ch
         wire logic [7:0] diff_up = target[g] - held[g];
         wire logic [7:0] diff_dn = held[g] - target[g];
         wire logic go_up = target[g] > held[g];
         wire logic go_dn = target[g] < held[g];
         // clamp so the last step lands on target
         wire logic [7:0] up_val = (diff_up < step[g]) ? target[g] : held[g] + step[g];
         wire logic [7:0] dn_val = (diff_dn < step[g]) ? target[g] : held[g] - step[g];
         wire logic [7:0] stepped = go_up ? up_val : (go_dn ? dn_val : held[g]);
         wire logic wr_duty = wr_now && (idx == IDX_DUTY_ONE + 8'(g));
         logic [7:0] next_held;
         assign next_held = !ramp_en[g] ? target[g] : (tick ? stepped : held[g]); // [RL9] [RL11] [RL6]

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               req[g] <= DUTY_RESET;
               held[g] <= DUTY_RESET; // [RL7]
               drive[g] <= 1'b0;
            end else begin
               if (wr_duty) req[g] <= dat_i[7:0]; // [RL7]
               held[g] <= next_held;
               drive[g] <= (slot < held[g]); // [RL8]
            end
         end
      end
   endgenerate

   assign fan_drive_one_o = drive[0];
   assign fan_drive_two_o = drive[1];
   assign fan_drive_three_o = drive[2];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_step_one_code0;
      (ramp_one[2:0] == 3'h0) |-> (step[0] == 8'h01);
   endproperty
   a_step_one_code0: assert property (p_step_one_code0) else $error("ch1 step wrong"); // [RL1]

   property p_step_three_code7;
      (ramp_two[2:0] == 3'h7) |-> (step[2] == 8'h30);
   endproperty
   a_step_three_code7: assert property (p_step_three_code7) else $error("ch3 step wrong"); // [RL2]

   property p_step_two_code4;
      (ramp_two[6:4] == 3'h4) |-> (step[1] == 8'h08);
   endproperty
   a_step_two_code4: assert property (p_step_two_code4) else $error("ch2 step wrong"); // [RL3]

   property p_tick_spacing;
      tick |=> !tick [*2];
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent"); // [RL4]

   property p_manual_slow;
      (ramp_en[0] && !auto_mode_i[0] && ramp_one[2:0] == 3'h0 && tick && held[0] < req[0])
         |=> (held[0] == $past(held[0]) + 8'h01);
   endproperty
   a_manual_slow: assert property (p_manual_slow) else $error("manual ramp not one slot"); // [RL5]

   property p_no_reverse;
      (ramp_en[0] && target[0] > held[0]) |=> (held[0] >= $past(held[0]));
   endproperty
   a_no_reverse: assert property (p_no_reverse) else $error("ramp reversed"); // [RL6]

   property p_duty_readback;
      (req_now && !we_i && hit_d2) |=> (ack_o && dat_o[7:0] == $past(held[1]));
   endproperty
   a_duty_readback: assert property (p_duty_readback) else $error("duty read wrong"); // [RL7]

   property p_slot_range;
      (slot == SLOT_LAST) |=> (slot == 8'h00);
   endproperty
   a_slot_range: assert property (p_slot_range) else $error("slot grid wrong"); // [RL8]

   property p_hold_between;
      (ramp_en[1] && !tick && $stable(ramp_en)) |=> (held[1] == $past(held[1]));
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("held moved off tick"); // [RL9]

   property p_disabled_follows;
      !ramp_en[2] |=> (held[2] == $past(target[2]));
   endproperty
   a_disabled_follows: assert property (p_disabled_follows) else $error("no follow"); // [RL10]

   property p_no_overshoot;
      (ramp_en[0] && tick && target[0] > held[0]) |=> (held[0] <= $past(target[0]));
   endproperty
   a_no_overshoot: assert property (p_no_overshoot) else $error("overshoot"); // [RL11]

   // bus answer and register storage
   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle"); // [RL7]

   property p_duty_write;
      (wr_now && hit_d1) |=> (req[0] == $past(dat_i[7:0]));
   endproperty
   a_duty_write: assert property (p_duty_write) else $error("duty request not stored"); // [RL7]

   property p_ramp_read;
      (req_now && !we_i && hit_r2) |=> (dat_o[7:0] == $past(ramp_two));
   endproperty
   a_ramp_read: assert property (p_ramp_read) else $error("ramp control read wrong"); // [RL3]

   // more step codes per channel
   property p_step_one_code7;
      (ramp_one[2:0] == 3'h7) |-> (step[0] == 8'h30);
   endproperty
   a_step_one_code7: assert property (p_step_one_code7) else $error("ch1 step 48 wrong"); // [RL1]

   property p_step_two_code5;
      (ramp_two[6:4] == 3'h5) |-> (step[1] == 8'h0c);
   endproperty
   a_step_two_code5: assert property (p_step_two_code5) else $error("ch2 step 12 wrong"); // [RL3]

   property p_step_three_code2;
      (ramp_two[2:0] == 3'h2) |-> (step[2] == 8'h03);
   endproperty
   a_step_three_code2: assert property (p_step_three_code2) else $error("ch3 step 3 wrong"); // [RL2]

   // pin level at the duty extremes
   property p_drive_full;
      (held[0] == 8'hff) |=> fan_drive_one_o;
   endproperty
   a_drive_full: assert property (p_drive_full) else $error("full duty pin not high"); // [RL8]

   property p_drive_off;
      (held[2] == 8'h00) |=> !fan_drive_three_o;
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("zero duty pin not low"); // [RL8]

   // ramp direction and landing on other channels
   property p_up_moves;
      (ramp_en[1] && tick && target[1] > held[1]) |=> (held[1] > $past(held[1]));
   endproperty
   a_up_moves: assert property (p_up_moves) else $error("ramp up stalled"); // [RL6]

   property p_down_moves;
      (ramp_en[2] && tick && target[2] < held[2]) |=> (held[2] < $past(held[2]));
   endproperty
   a_down_moves: assert property (p_down_moves) else $error("ramp down stalled"); // [RL9]

   property p_down_lands;
      (ramp_en[2] && tick && target[2] < held[2]) |=> (held[2] >= $past(target[2]));
   endproperty
   a_down_lands: assert property (p_down_lands) else $error("ramp down overshoot"); // [RL11]

   property p_tick_wrap;
      tick |=> (tick_cnt == 32'h0000_0000);
   endproperty
   a_tick_wrap: assert property (p_tick_wrap) else $error("pacing counter not wrapped"); // [RL4]

   property p_disabled_two;
      !ramp_en[1] |=> (held[1] == $past(target[1]));
   endproperty
   a_disabled_two: assert property (p_disabled_two) else $error("ch2 no follow"); // [RL10]
endmodule
`default_nettype wire

/* File: test/fan_load_model.sv */
// fan load model: measures pin duty over 255-slot frames
`timescale 1ns/1ps
`default_nettype none
module fan_load_model (
   // clock and drive pin
   input wire logic clk_i,
   input wire logic pin_i,
   // high slots counted in the last frame
   output logic [7:0] duty_seen_o
);
   int slot = 0;
   int high = 0;
   // count high slots, latch once per frame of 255 slots
   always @(posedge clk_i) begin
      if (slot == 254) begin
         duty_seen_o <= 8'(high + int'(pin_i));
         high = 0;
         slot = 0;
      end else begin
         high = high + int'(pin_i);
         slot = slot + 1;
      end
   end
endmodule
`default_nettype wire

/* File: test/fan_pwm_ramp_limiter_tb_top.sv */
// bench for the fan duty ramp limiter
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_ramp_limiter_tb_top;
   import fan_ramp_pkg::*;
   localparam int UP = 20;
   localparam int STEPS [8] = '{1, 2, 3, 5, 8, 12, 24, 48};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [9:0] adr_i = 10'h000;
   logic [3:0] sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic [2:0] auto_mode_i = 3'h0;
   logic [7:0] tgt [3] = '{default: 8'h00};
   logic [2:0] drive;
   logic [7:0] seen [3];
   logic [31:0] q;
   logic [7:0] h1;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;

   // clock and design under test
   always #10 clk_i = ~clk_i;
   fan_pwm_ramp_limiter #(.UPDATE_PERIOD(UP)) fan_pwm_ramp_limiter_i (.clk_i(clk_i),
      .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .auto_mode_i(auto_mode_i), .target_one_i(tgt[0]), .target_two_i(tgt[1]),
      .target_three_i(tgt[2]), .fan_drive_one_o(drive[0]),
      .fan_drive_two_o(drive[1]), .fan_drive_three_o(drive[2]));
   for (genvar g = 0; g < 3; g++) begin : fan
      fan_load_model fan_load_model_i (.clk_i(clk_i), .pin_i(drive[g]),
         .duty_seen_o(seen[g]));
   end

   task automatic test_done();
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   // one classic wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 20) chk("ack", 32'h1, 32'h0);
      @(posedge clk_i);
   endtask

   // ramp full scale up then down, checking pacing and landing
   task automatic ramp(input int ch, input logic [2:0] code);
      int n;
      logic [7:0] ri;
      logic [7:0] rv;
      logic [7:0] t;
      int lo;
      n = (254 + STEPS[code]) / STEPS[code];
      lo = (n - 2) * STEPS[code];
      ri = (ch == 0) ? IDX_RAMP_ONE : IDX_RAMP_TWO;
      rv = (ch == 1) ? {1'b1, code, 4'h0} : {5'h01, code};
      wb(1'b1, ri, 8'h00);
      wb(1'b1, IDX_DUTY_ONE + 8'(ch), 8'h00);
      wb(1'b1, ri, rv);
      for (int d = 0; d < 2; d++) begin
         t = (d == 0) ? 8'hff : 8'h00;
         wb(1'b1, IDX_DUTY_ONE + 8'(ch), t);
         repeat ((n - 2) * UP) @(posedge clk_i);
         wb(1'b0, IDX_DUTY_ONE + 8'(ch), 8'h00);
         chk("ramp_mid", 32'h1, {31'h0, (d == 0) ? (q[7:0] < t) : (q[7:0] > t)});
         chk("ramp_pace", 32'h1, {31'h0, (d == 0) ? (int'(q[7:0]) >= lo) : (int'(q[7:0]) <= 255 - lo)});
         repeat (3 * UP) @(posedge clk_i);
         wb(1'b0, IDX_DUTY_ONE + 8'(ch), 8'h00);
         chk("ramp_end", {24'h0, t}, q);
         repeat (520) @(posedge clk_i);
         chk("fan_duty", {24'h0, t}, {24'h0, seen[ch]});
      end
   endtask

   // cycle ceiling against hangs
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         err_count++;
         test_done();
      end
   end

   // main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, IDX_DUTY_ONE, 8'h00);
      chk("duty_one_rst", 32'hff, q);
      wb(1'b0, IDX_DUTY_TWO, 8'h00);
      chk("duty_two_rst", 32'hff, q);
      wb(1'b0, IDX_RAMP_TWO, 8'h00);
      chk("ramp_two_rst", 32'h0, q);
      wb(1'b1, 8'h10, 8'h5a);
      wb(1'b0, 8'h10, 8'h00);
      chk("unmapped", 32'h0, q);
      wb(1'b1, IDX_DUTY_TWO, 8'h55);
      wb(1'b0, IDX_DUTY_TWO, 8'h00);
      chk("duty_two_rw", 32'h55, q);
      repeat (520) @(posedge clk_i);
      chk("fan_two_duty", 32'h55, {24'h0, seen[1]});
      sel_i <= 4'he;
      wb(1'b1, IDX_DUTY_TWO, 8'h33);
      sel_i <= 4'hf;
      wb(1'b0, IDX_DUTY_TWO, 8'h00);
      chk("sel_masked", 32'h55, q);
      for (int c = 0; c < 8; c++) ramp(0, 3'(c));
      for (int c = 1; c < 8; c++) ramp(1, 3'(c));
      for (int c = 1; c < 8; c++) ramp(2, 3'(c));
      wb(1'b1, IDX_RAMP_ONE, 8'h00);
      auto_mode_i <= 3'b001;
      repeat (3) @(posedge clk_i);
      wb(1'b1, IDX_RAMP_ONE, 8'h08);
      tgt[0] <= 8'hc8;
      repeat (30 * UP) @(posedge clk_i);
      wb(1'b0, IDX_DUTY_ONE, 8'h00);
      h1 = q[7:0];
      tgt[0] <= 8'h96;
      repeat (10 * UP) @(posedge clk_i);
      wb(1'b0, IDX_DUTY_ONE, 8'h00);
      chk("no_reverse", 32'h1, {31'h0, q[7:0] > h1});
      h1 = q[7:0];
      tgt[0] <= 8'h00;
      repeat (5 * UP) @(posedge clk_i);
      wb(1'b0, IDX_DUTY_ONE, 8'h00);
      chk("auto_down", 32'h1, {31'h0, q[7:0] < h1});
      wb(1'b1, IDX_RAMP_TWO, 8'h00);
      auto_mode_i <= 3'b111;
      tgt[1] <= 8'h40;
      tgt[2] <= 8'h20;
      repeat (2) @(posedge clk_i);
      wb(1'b0, IDX_DUTY_TWO, 8'h00);
      chk("auto_two", 32'h40, q);
      wb(1'b0, IDX_DUTY_THREE, 8'h00);
      chk("auto_three", 32'h20, q);
      test_done();
   end
endmodule
`default_nettype wire
